// file: osr_pkg.sv
// Shared constants: opcodes, address fields, timing and the host register map.
package osr_pkg;
	localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_RD_STAT1   = 8'h05;
	localparam logic [7:0] OP_RD_STAT2   = 8'h35;
	localparam logic [7:0] OP_RD_STAT3   = 8'h15;
	localparam logic [7:0] OP_WR_STAT2   = 8'h31;
	localparam logic [7:0] OP_SET_RDPAR  = 8'hc0;
	localparam logic [7:0] OP_AREA_ERASE = 8'h44;
	localparam logic [7:0] OP_AREA_PROG  = 8'h42;
	localparam logic [7:0] OP_AREA_READ  = 8'h48;

	localparam int AREA_COUNT = 3;
	localparam int AREA_BYTES = 1024;
	localparam int MEM_BYTES  = AREA_COUNT * AREA_BYTES;
	localparam int MEM_AW     = 12;

	localparam logic [7:0] ADDR_HIGH_ZERO = 8'h00;
	localparam logic [1:0] ADDR_GAP_ZERO  = 2'h0;
	localparam logic [3:0] ADDR_AREA_MIN  = 4'h1;
	localparam logic [3:0] ADDR_AREA_MAX  = 4'h3;

	localparam int STAT_BUSY_POS  = 0;
	localparam int STAT_WEN_POS   = 1;
	localparam int STAT_LOCK_POS  = 3;
	localparam int STAT_DELIV_POS = 6;
	localparam int RDPAR_LSB      = 4;

	localparam logic [1:0] RDPAR_DEFAULT = 2'h3;
	localparam logic [3:0] SPI_DUMMY_CLKS = 4'h8;
	localparam logic [7:0] ERASED_BYTE    = 8'hff;

	localparam int CLK_MHZ                  = 200;
	localparam int SECTOR_ERASE_TIME_US     = 1000;
	localparam int PAGE_PROGRAM_TIME_US     = 100;
	localparam int POWER_ON_SELECT_DELAY_US = 200;
	localparam int ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
	localparam int PROG_CYC  = PAGE_PROGRAM_TIME_US * CLK_MHZ;
	localparam int POR_CYC   = POWER_ON_SELECT_DELAY_US * CLK_MHZ;
	localparam logic [3:0] SCLK_HALF = 4'h8;

	localparam logic [31:0] REG_ADDR = 32'h0000_0000;
	localparam logic [31:0] REG_TXD  = 32'h0000_0004;
	localparam logic [31:0] REG_CTRL = 32'h0000_0008;
	localparam logic [31:0] REG_STAT = 32'h0000_000c;
	localparam logic [31:0] REG_RXD  = 32'h0000_0010;
	localparam int CTRL_ADDR_POS = 8;
	localparam int CTRL_DUM_LSB  = 12;
	localparam int CTRL_CNT_LSB  = 16;
	localparam int CTRL_RX_POS   = 20;
	localparam logic [2:0] MAX_DATA_BYTES = 3'h4;

	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_LEAD  = 3'b001,
		H_LOW   = 3'b010,
		H_HIGH  = 3'b011,
		H_TRAIL = 3'b100,
		H_GAP   = 3'b101
	} osr_hstate_t;
endpackage

// file: osr_link_if.sv
// Serial link between the host controller and the device.
`timescale 1ns/100ps
interface osr_link_if;
	logic sclk;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe;
	modport dev  (input sclk, input cs_n, input si, output so, output so_oe);
	modport host (output sclk, output cs_n, output si, input so, input so_oe);
endinterface

// file: osr_dev.sv
// Device end: security-area erase, program and read command handling.
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// - Three separate 1024-byte areas, erased whole.
// - Host sends write enable before erase/program.
// - Erase runs only if select rises at boundary.
// - Select rise starts timed erase cycle.
// - Busy bit high during cycle, readable.
// - Write enable latch clears before cycle ends.
// - Locked area ignores erase.
// - Area chosen by address bits 15 to 12.
// - Host programs 1 to 1024 bytes.
// - Select rise starts timed program cycle.
// - Locked area ignores program.
// - Command, address, dummy latched on rising clock.
// - Read data shifted out on falling clock.
// - Read starts anywhere, address advances per byte.
// - Low address wraps 3FFH to 000H.
// - Quad mode read dummy count from parameter.
// - Parameter encodes 2,4,6,8; default 8.
// - Areas erased, status zero except delivered bit.
module osr_dev #(
	parameter int ERASE_CYC = osr_pkg::ERASE_CYC,
	parameter int PROG_CYC  = osr_pkg::PROG_CYC
) (
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic       quad_command_mode,
	output logic            write_in_progress,
	output logic            write_enable_latch,
	output logic [2:0]      area_lock,
	osr_link_if.dev         link
);
	logic [2:0]  sclk_s_q;
	logic [2:0]  cs_s_q;
	logic [1:0]  si_s_q;
	logic [2:0]  bit_q;
	logic [2:0]  byte_q;
	logic [6:0]  sh_q;
	logic [7:0]  cmd_q;
	logic [23:0] addr_q;
	logic [3:0]  dum_q;
	logic [2:0]  obit_q;
	logic [6:0]  osh_q;
	logic        so_q;
	logic        so_oe_q;
	logic        busy_q;
	logic        wen_q;
	logic [2:0]  lock_q;
	logic [1:0]  rdpar_q;
	logic [31:0] busy_cnt_q;
	logic        prog_hit_q;
	logic [7:0]  mem_q [0:osr_pkg::MEM_BYTES-1];

	logic        rise;
	logic        fall;
	logic        cs_low;
	logic        cs_fall;
	logic        cs_rise;
	logic [7:0]  in_byte;
	logic        byte_done;
	logic        area_ok;
	logic [1:0]  area_idx;
	logic        lock_hit;
	logic        may_write;
	logic        prog_wr;
	logic        erase_go;
	logic        prog_go;
	logic        lock_go;
	logic [3:0]  dummy_n;
	logic        is_stat;
	logic        data_ph;
	logic [7:0]  src_byte;
	logic [11:0] mem_idx;

	always_ff @(posedge clock) begin
		if (srst) begin
			sclk_s_q <= 3'h0;
			cs_s_q   <= 3'h7;
			si_s_q   <= 2'h0;
		end else begin
			sclk_s_q <= {sclk_s_q[1:0], link.sclk};
			cs_s_q   <= {cs_s_q[1:0], link.cs_n};
			si_s_q   <= {si_s_q[0], link.si};
		end
	end

	assign rise      = sclk_s_q[1] & ~sclk_s_q[2];
	assign fall      = ~sclk_s_q[1] & sclk_s_q[2];
	assign cs_low    = ~cs_s_q[1];
	assign cs_fall   = ~cs_s_q[1] & cs_s_q[2];
	assign cs_rise   = cs_s_q[1] & ~cs_s_q[2];
	assign in_byte   = {sh_q, si_s_q[1]};
	assign byte_done = cs_low & rise & (bit_q == 3'h7);

	assign area_ok = (addr_q[23:16] == osr_pkg::ADDR_HIGH_ZERO) &
		(addr_q[11:10] == osr_pkg::ADDR_GAP_ZERO) &
		(addr_q[15:12] >= osr_pkg::ADDR_AREA_MIN) &
		(addr_q[15:12] <= osr_pkg::ADDR_AREA_MAX);
	assign area_idx  = addr_q[13:12] - 2'h1;
	assign lock_hit  = lock_q[area_idx];
	assign may_write = wen_q & ~busy_q & area_ok & ~lock_hit;
	assign mem_idx   = {area_idx, addr_q[9:0]};

	assign prog_wr  = byte_done & (cmd_q == osr_pkg::OP_AREA_PROG) & (byte_q >= 3'h4) & may_write;
	assign erase_go = cs_rise & (cmd_q == osr_pkg::OP_AREA_ERASE) & (byte_q == 3'h4) &
		(bit_q == 3'h0) & may_write;
	assign prog_go  = cs_rise & (cmd_q == osr_pkg::OP_AREA_PROG) & prog_hit_q;
	assign lock_go  = cs_rise & (cmd_q == osr_pkg::OP_WR_STAT2) & (byte_q == 3'h2) &
		(bit_q == 3'h0) & wen_q & ~busy_q;

	// Dummy clocks: fixed in single-line mode, parameter-driven in quad mode.
	assign dummy_n = quad_command_mode ? {1'b0, rdpar_q, 1'b0} + 4'h2 :
		osr_pkg::SPI_DUMMY_CLKS;
	assign is_stat = (cmd_q == osr_pkg::OP_RD_STAT1) | (cmd_q == osr_pkg::OP_RD_STAT2) |
		(cmd_q == osr_pkg::OP_RD_STAT3);
	assign data_ph = cs_low & ((is_stat & (byte_q != 3'h0)) |
		((cmd_q == osr_pkg::OP_AREA_READ) & (byte_q >= 3'h4) & (dum_q == dummy_n)));

	always_comb begin
		src_byte = 8'h00;
		case (cmd_q)
			osr_pkg::OP_RD_STAT1: begin
				src_byte[osr_pkg::STAT_BUSY_POS] = busy_q;
				src_byte[osr_pkg::STAT_WEN_POS]  = wen_q;
			end
			osr_pkg::OP_RD_STAT2: begin
				src_byte[osr_pkg::STAT_LOCK_POS +: 3] = lock_q;
			end
			osr_pkg::OP_RD_STAT3: begin
				src_byte[osr_pkg::STAT_DELIV_POS] = 1'b1;
			end
			default: begin
				src_byte = area_ok ? mem_q[mem_idx] : osr_pkg::ERASED_BYTE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst || cs_fall) begin
			bit_q  <= 3'h0;
			byte_q <= 3'h0;
			sh_q   <= 7'h00;
			cmd_q  <= 8'h00;
			addr_q <= 24'h000000;
		end else begin
			if (cs_low && rise) begin
				bit_q <= bit_q + 3'h1;
				sh_q  <= in_byte[6:0];
			end
			if (byte_done) begin
				if (byte_q != 3'h7) begin
					byte_q <= byte_q + 3'h1;
				end
				if (byte_q == 3'h0) begin
					cmd_q <= in_byte;
				end else if (byte_q <= 3'h3) begin
					addr_q <= {addr_q[15:0], in_byte};
				end
			end
			if (prog_wr || (data_ph && fall && obit_q == 3'h0 && !is_stat)) begin
				addr_q[9:0] <= addr_q[9:0] + 10'h001;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst || cs_fall) begin
			dum_q <= 4'h0;
		end else if (cs_low && rise && cmd_q == osr_pkg::OP_AREA_READ &&
			byte_q >= 3'h4 && dum_q != dummy_n) begin
			dum_q <= dum_q + 4'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst || cs_fall) begin
			obit_q  <= 3'h0;
			osh_q   <= 7'h00;
			so_q    <= 1'b0;
			so_oe_q <= 1'b0;
		end else begin
			so_oe_q <= data_ph;
			if (data_ph && fall) begin
				obit_q <= obit_q + 3'h1;
				if (obit_q == 3'h0) begin
					so_q  <= src_byte[7];
					osh_q <= src_byte[6:0];
				end else begin
					so_q  <= osh_q[6];
					osh_q <= {osh_q[5:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < osr_pkg::MEM_BYTES; i++) begin
				mem_q[i] <= osr_pkg::ERASED_BYTE;
			end
		end else if (erase_go) begin
			for (int i = 0; i < osr_pkg::AREA_BYTES; i++) begin
				mem_q[{area_idx, i[9:0]}] <= osr_pkg::ERASED_BYTE;
			end
		end else if (prog_wr) begin
			mem_q[mem_idx] <= mem_q[mem_idx] & in_byte;
		end
	end

	always_ff @(posedge clock) begin
		if (srst || cs_fall) begin
			prog_hit_q <= 1'b0;
		end else if (prog_wr) begin
			prog_hit_q <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			busy_cnt_q <= 32'h0;
			busy_q     <= 1'b0;
		end else if (erase_go) begin
			busy_cnt_q <= ERASE_CYC;
			busy_q     <= 1'b1;
		end else if (prog_go) begin
			busy_cnt_q <= PROG_CYC;
			busy_q     <= 1'b1;
		end else if (busy_cnt_q != 32'h0) begin
			busy_cnt_q <= busy_cnt_q - 32'h1;
			busy_q     <= (busy_cnt_q != 32'h1);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			wen_q <= 1'b0;
		end else if (erase_go || prog_go || lock_go) begin
			wen_q <= 1'b0;
		end else if (cs_rise && !busy_q && byte_q == 3'h1 && bit_q == 3'h0) begin
			if (cmd_q == osr_pkg::OP_WR_ENABLE) begin
				wen_q <= 1'b1;
			end else if (cmd_q == osr_pkg::OP_WR_DISABLE) begin
				wen_q <= 1'b0;
			end
		end
	end

	// Lock bits never cleared except by reset.
	always_ff @(posedge clock) begin
		if (srst) begin
			lock_q <= 3'h0;
		end else if (lock_go) begin
			lock_q <= lock_q | addr_q[osr_pkg::STAT_LOCK_POS +: 3];
		end
	end

	always_ff @(posedge clock) begin
		if (srst || !quad_command_mode) begin
			rdpar_q <= osr_pkg::RDPAR_DEFAULT;
		end else if (byte_done && byte_q == 3'h1 && cmd_q == osr_pkg::OP_SET_RDPAR) begin
			rdpar_q <= in_byte[osr_pkg::RDPAR_LSB +: 2];
		end
	end

	assign link.so            = so_q;
	assign link.so_oe         = so_oe_q;
	assign write_in_progress  = busy_q;
	assign write_enable_latch = wen_q;
	assign area_lock          = lock_q;
endmodule

// file: osr_host.sv
// Host end: serial flash controller with an AHB-Lite register port.
`timescale 1ns/100ps
module osr_host #(
	parameter int POR_CYC = osr_pkg::POR_CYC
) (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	osr_link_if.host         link
);
	osr_pkg::osr_hstate_t st_q;
	logic [31:0] ad_q;
	logic        wr_pend_q;
	logic [31:0] rdata_q;
	logic [23:0] addr_q;
	logic [31:0] txd_q;
	logic [31:0] rxd_q;
	logic [7:0]  op_q;
	logic        has_addr_q;
	logic [3:0]  dum_q;
	logic [2:0]  cnt_q;
	logic        rx_q;
	logic [31:0] por_q;
	logic        por_done_q;
	logic [3:0]  div_q;
	logic [6:0]  bit_q;
	logic [31:0] hsh_q;
	logic [31:0] dsh_q;
	logic [6:0]  rsh_q;
	logic        sclk_q;
	logic        cs_n_q;
	logic        si_q;
	logic [1:0]  so_s_q;

	logic        go;
	logic        tick;
	logic [6:0]  hdr_n;
	logic [6:0]  pre_n;
	logic [6:0]  tot_n;
	logic        in_hdr;
	logic        in_dat;
	logic [6:0]  dpos;
	logic [2:0]  cnt_w;
	logic [31:0] rd_mux;

	assign hdr_n  = has_addr_q ? 7'h20 : 7'h08;
	assign pre_n  = hdr_n + {3'h0, dum_q};
	assign tot_n  = pre_n + {1'b0, cnt_q, 3'h0};
	assign in_hdr = bit_q < hdr_n;
	assign in_dat = bit_q >= pre_n;
	assign dpos   = bit_q - pre_n;
	assign tick   = div_q == osr_pkg::SCLK_HALF - 4'h1;
	assign go     = wr_pend_q && ad_q == osr_pkg::REG_CTRL && st_q == osr_pkg::H_IDLE &&
		por_done_q;
	assign cnt_w  = hwdata[osr_pkg::CTRL_CNT_LSB +: 3] > osr_pkg::MAX_DATA_BYTES ?
		osr_pkg::MAX_DATA_BYTES : hwdata[osr_pkg::CTRL_CNT_LSB +: 3];

	always_comb begin
		case (haddr)
			osr_pkg::REG_ADDR: rd_mux = {8'h00, addr_q};
			osr_pkg::REG_TXD:  rd_mux = txd_q;
			osr_pkg::REG_CTRL: rd_mux = {11'h0, rx_q, 1'b0, cnt_q, dum_q, 3'h0, has_addr_q, op_q};
			osr_pkg::REG_STAT: rd_mux = {30'h0, por_done_q, st_q != osr_pkg::H_IDLE};
			osr_pkg::REG_RXD:  rd_mux = rxd_q;
			default:           rd_mux = 32'h0;
		endcase
	end

	// AHB-Lite slave, zero wait states, always OKAY.
	always_ff @(posedge clock) begin
		if (srst) begin
			wr_pend_q <= 1'b0;
			ad_q      <= 32'h0;
			rdata_q   <= 32'h0;
		end else begin
			wr_pend_q <= hsel & hready & htrans[1] & hwrite;
			if (hsel && hready && htrans[1]) begin
				ad_q    <= haddr;
				rdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			addr_q     <= 24'h0;
			txd_q      <= 32'h0;
			op_q       <= 8'h0;
			has_addr_q <= 1'b0;
			dum_q      <= 4'h0;
			cnt_q      <= 3'h0;
			rx_q       <= 1'b0;
		end else if (wr_pend_q && st_q == osr_pkg::H_IDLE) begin
			if (ad_q == osr_pkg::REG_ADDR) begin
				addr_q <= hwdata[23:0];
			end
			if (ad_q == osr_pkg::REG_TXD) begin
				txd_q <= hwdata;
			end
			if (go) begin
				op_q       <= hwdata[7:0];
				has_addr_q <= hwdata[osr_pkg::CTRL_ADDR_POS];
				dum_q      <= hwdata[osr_pkg::CTRL_DUM_LSB +: 4];
				cnt_q      <= cnt_w;
				rx_q       <= hwdata[osr_pkg::CTRL_RX_POS];
			end
		end
	end

	// Power-on wait before the first select.
	always_ff @(posedge clock) begin
		if (srst) begin
			por_q      <= 32'h0;
			por_done_q <= 1'b0;
		end else if (!por_done_q) begin
			por_q      <= por_q + 32'h1;
			por_done_q <= por_q >= POR_CYC - 1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			so_s_q <= 2'h0;
		end else begin
			so_s_q <= {so_s_q[0], link.so};
		end
	end

	// Frame engine: sclk mode 0 made by dividing the system clock.
	always_ff @(posedge clock) begin
		if (srst) begin
			st_q   <= osr_pkg::H_IDLE;
			div_q  <= 4'h0;
			bit_q  <= 7'h0;
			hsh_q  <= 32'h0;
			dsh_q  <= 32'h0;
			rsh_q  <= 7'h0;
			rxd_q  <= 32'h0;
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			div_q <= (st_q == osr_pkg::H_IDLE || tick) ? 4'h0 : div_q + 4'h1;
			case (st_q)
				osr_pkg::H_IDLE: begin
					if (go) begin
						hsh_q  <= hwdata[osr_pkg::CTRL_ADDR_POS] ?
							{hwdata[7:0], addr_q} : {hwdata[7:0], 24'h0};
						dsh_q  <= {txd_q[7:0], txd_q[15:8], txd_q[23:16], txd_q[31:24]};
						bit_q  <= 7'h0;
						cs_n_q <= 1'b0;
						st_q   <= osr_pkg::H_LEAD;
					end
				end
				osr_pkg::H_LEAD: begin
					if (tick) begin
						st_q <= osr_pkg::H_LOW;
					end
				end
				osr_pkg::H_LOW: begin
					if (tick) begin
						sclk_q <= 1'b1;
						st_q   <= osr_pkg::H_HIGH;
						if (in_dat && rx_q) begin
							rsh_q <= {rsh_q[5:0], so_s_q[1]};
							if (dpos[2:0] == 3'h7) begin
								rxd_q[{dpos[4:3], 3'h0} +: 8] <= {rsh_q, so_s_q[1]};
							end
						end
					end
				end
				osr_pkg::H_HIGH: begin
					if (tick) begin
						sclk_q <= 1'b0;
						bit_q  <= bit_q + 7'h1;
						if (in_hdr) begin
							hsh_q <= {hsh_q[30:0], 1'b0};
						end
						if (in_dat) begin
							dsh_q <= {dsh_q[30:0], 1'b0};
						end
						st_q <= (bit_q + 7'h1 == tot_n) ? osr_pkg::H_TRAIL : osr_pkg::H_LOW;
					end
				end
				osr_pkg::H_TRAIL: begin
					if (tick) begin
						cs_n_q <= 1'b1;
						st_q   <= osr_pkg::H_GAP;
					end
				end
				osr_pkg::H_GAP: begin
					if (tick) begin
						st_q <= osr_pkg::H_IDLE;
					end
				end
				default: begin
					st_q <= osr_pkg::H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst || st_q == osr_pkg::H_IDLE) begin
			si_q <= 1'b0;
		end else begin
			si_q <= in_hdr ? hsh_q[31] : (in_dat ? dsh_q[31] : 1'b0);
		end
	end

	assign hrdata    = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign link.sclk = sclk_q;
	assign link.cs_n = cs_n_q;
	assign link.si   = si_q;
endmodule

// file: osr_properties.sv
// Concurrent checks on the serial link and the device status outputs.
`timescale 1ns/100ps
module osr_properties #(
	parameter int ERASE_CYC = 200,
	parameter int PROG_CYC  = 100
) (
	input wire logic       clock,
	input wire logic       srst,
	input wire logic       sclk,
	input wire logic       cs_n,
	input wire logic       si,
	input wire logic       so,
	input wire logic       so_oe,
	input wire logic       write_in_progress,
	input wire logic       write_enable_latch,
	input wire logic [2:0] area_lock
);
	logic [31:0] run_q;

	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	// Counts the cycles of one busy period.
	always_ff @(posedge clock) begin
		if (srst || !write_in_progress) begin
			run_q <= 32'h0;
		end else begin
			run_q <= run_q + 32'h1;
		end
	end

	a_clock_idle_low: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	a_si_held_high: assert property (sclk && $past(sclk) |-> $stable(si))
		else $error("si moved while serial clock high");
	a_so_held_high: assert property (sclk && $past(sclk) && so_oe && $past(so_oe) |->
		$stable(so))
		else $error("so moved while serial clock high");
	a_out_off_idle: assert property ($rose(cs_n) |-> ##[1:8] !so_oe)
		else $error("so still driven after deselect");
	a_cycle_after_rise: assert property ($rose(write_in_progress) |-> cs_n && $past(cs_n, 2))
		else $error("busy cycle began while selected");
	a_latch_cleared_end: assert property ($fell(write_in_progress) |-> !write_enable_latch)
		else $error("write enable still set after cycle");
	a_cycle_length: assert property ($fell(write_in_progress) |->
		run_q == ERASE_CYC || run_q == PROG_CYC)
		else $error("busy period of wrong length");
	a_lock_sticky: assert property (($past(area_lock) & ~area_lock) == 3'h0)
		else $error("lock bit cleared");
	a_latch_needed: assert property ($rose(write_in_progress) |->
		$past(write_enable_latch) || $past(write_enable_latch, 2))
		else $error("cycle started without write enable");

	cover property ($rose(write_in_progress));
	cover property ($rose(so_oe));
	cover property ($rose(|area_lock));
endmodule

// file: osr_tb.sv
// Testbench joining the host and device ends over the serial link.
`timescale 1ns/100ps
module osr_tb;
	typedef struct {
		logic [2:0]  f;
		logic [7:0]  op;
		logic [23:0] a;
		logic [3:0]  dm;
		logic [2:0]  n;
		logic [15:0] tx;
		logic [31:0] ex;
	} osr_row_t;
	localparam int ECYC = 800;
	localparam int PCYC = 400;
	logic        clock;
	logic        srst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        quad_command_mode;
	logic        write_in_progress;
	logic        write_enable_latch;
	logic [2:0]  area_lock;
	logic [31:0] rd;
	logic        rx_on;
	int          error_cnt;
	int          num_checks;
	osr_row_t    rows [26];
	osr_link_if  link ();

	osr_host #(.POR_CYC(50)) i_osr_host (.clock(clock), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.link(link.host));
	osr_dev #(.ERASE_CYC(ECYC), .PROG_CYC(PCYC)) i_osr_dev (.clock(clock), .srst(srst),
		.quad_command_mode(quad_command_mode), .write_in_progress(write_in_progress),
		.write_enable_latch(write_enable_latch), .area_lock(area_lock), .link(link.dev));
	osr_properties #(.ERASE_CYC(ECYC), .PROG_CYC(PCYC)) i_osr_properties (.clock(clock),
		.srst(srst), .sclk(link.sclk), .cs_n(link.cs_n), .si(link.si), .so(link.so),
		.so_oe(link.so_oe), .write_in_progress(write_in_progress),
		.write_enable_latch(write_enable_latch), .area_lock(area_lock));

	task automatic conclude();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bound(input logic ok);
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("Error at %0t: wait timed out", $time);
			conclude();
		end
	endtask

	task automatic wait_ready();
		for (int k = 0; k < 100; k++) begin
			@(posedge clock);
			if (hreadyout === 1'b1) begin
				break;
			end
		end
		bound(hreadyout === 1'b1);
	endtask

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask

	task automatic por_wait();
		int k;
		k = 0;
		do begin
			ahb(1'b0, osr_pkg::REG_STAT, 32'h0);
			k++;
		end while (rd[1] !== 1'b1 && k < 200);
		bound(rd[1] === 1'b1);
	endtask

	task automatic idle_wait();
		for (int k = 0; k < 2000 && write_in_progress !== 1'b0; k++) begin
			@(posedge clock);
		end
		bound(write_in_progress === 1'b0);
	endtask

	task automatic frame(input logic [7:0] op, input logic ae, input logic [23:0] a,
			input logic [3:0] dm, input logic [2:0] n, input logic [15:0] tx);
		logic [31:0] mask;
		int          k;
		rx_on = op inside {8'h05, 8'h15, 8'h35, 8'h48};
		mask = (n > 3'h3) ? 32'hffffffff : (32'h1 << (8 * n)) - 32'h1;
		ahb(1'b1, osr_pkg::REG_ADDR, {8'h0, a});
		ahb(1'b1, osr_pkg::REG_TXD, {16'h0, tx});
		ahb(1'b1, osr_pkg::REG_CTRL, {11'h0, rx_on, 1'b0, n, dm, 3'h0, ae, op});
		ahb(1'b0, osr_pkg::REG_STAT, 32'h0);
		k = 0;
		do begin
			ahb(1'b0, osr_pkg::REG_STAT, 32'h0);
			k++;
		end while (rd[0] !== 1'b0 && k < 2000);
		bound(rd[0] === 1'b0);
		ahb(1'b0, osr_pkg::REG_RXD, 32'h0);
		rd = rd & mask;
	endtask

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		rows = '{
			'{3'h0, 8'h15, 24'h0, 4'h0, 3'h1, 16'h0, 32'h40},
			'{3'h0, 8'h05, 24'h0, 4'h0, 3'h1, 16'h0, 32'h0},
			'{3'h0, 8'h35, 24'h0, 4'h0, 3'h1, 16'h0, 32'h0},
			'{3'h0, 8'h48, 24'h001000, 4'h8, 3'h4, 16'h0, 32'hffffffff},
			'{3'h0, 8'h42, 24'h0013fe, 4'h0, 3'h2, 16'h2211, 32'h0},
			'{3'h0, 8'h48, 24'h0013fe, 4'h8, 3'h4, 16'h0, 32'hffffffff},
			'{3'h2, 8'h05, 24'h0, 4'h0, 3'h1, 16'h0, 32'h02},
			'{3'h0, 8'h42, 24'h0013fe, 4'h0, 3'h2, 16'h2211, 32'h0},
			'{3'h0, 8'h05, 24'h0, 4'h0, 3'h1, 16'h0, 32'h01},
			'{3'h1, 8'h48, 24'h0013fe, 4'h8, 3'h4, 16'h0, 32'hffff2211},
			'{3'h0, 8'h48, 24'h0023fe, 4'h8, 3'h4, 16'h0, 32'hffffffff},
			'{3'h2, 8'h44, 24'h001000, 4'h0, 3'h0, 16'h0, 32'h0},
			'{3'h0, 8'h05, 24'h0, 4'h0, 3'h1, 16'h0, 32'h01},
			'{3'h1, 8'h48, 24'h0013fe, 4'h8, 3'h4, 16'h0, 32'hffffffff},
			'{3'h2, 8'h42, 24'h004000, 4'h0, 3'h1, 16'h55, 32'h0},
			'{3'h0, 8'h05, 24'h0, 4'h0, 3'h1, 16'h0, 32'h02},
			'{3'h0, 8'h42, 24'h003000, 4'h0, 3'h1, 16'h77, 32'h0},
			'{3'h1, 8'h48, 24'h013000, 4'h8, 3'h1, 16'h0, 32'hff},
			'{3'h0, 8'h48, 24'h003000, 4'h8, 3'h1, 16'h0, 32'h77},
			'{3'h2, 8'h31, 24'h0, 4'h0, 3'h1, 16'h08, 32'h0},
			'{3'h1, 8'h35, 24'h0, 4'h0, 3'h1, 16'h0, 32'h08},
			'{3'h2, 8'h42, 24'h001000, 4'h0, 3'h1, 16'h0, 32'h0},
			'{3'h1, 8'h48, 24'h001000, 4'h8, 3'h1, 16'h0, 32'hff},
			'{3'h2, 8'h44, 24'h001000, 4'h0, 3'h0, 16'h0, 32'h0},
			'{3'h0, 8'h05, 24'h0, 4'h0, 3'h1, 16'h0, 32'h02},
			'{3'h4, 8'h48, 24'h003000, 4'h8, 3'h1, 16'h0, 32'h77}};
		error_cnt = 0;
		num_checks = 0;
		srst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		quad_command_mode = 1'b0;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		por_wait();
		foreach (rows[i]) begin
			if (rows[i].f[0]) begin
				idle_wait();
			end
			quad_command_mode <= rows[i].f[2];
			if (rows[i].f[1]) begin
				frame(8'h06, 1'b0, 24'h0, 4'h0, 3'h0, 16'h0);
			end
			frame(rows[i].op, rows[i].op inside {8'h42, 8'h44, 8'h48}, rows[i].a,
				rows[i].dm, rows[i].n, rows[i].tx);
			if (rx_on) begin
				chk(rd, rows[i].ex);
			end
		end
		for (int p = 3; p >= 0; p--) begin
			frame(8'hc0, 1'b0, 24'h0, 4'h0, 3'h1, {10'h0, p[1:0], 4'h0});
			frame(8'h48, 1'b1, 24'h003000, {1'b0, p[1:0], 1'b0} + 4'h2, 3'h1, 16'h0);
			chk(rd, 32'h77);
		end
		quad_command_mode <= 1'b0;
		@(posedge clock);
		quad_command_mode <= 1'b1;
		frame(8'h48, 1'b1, 24'h003000, 4'h8, 3'h1, 16'h0);
		chk(rd, 32'h77);
		quad_command_mode <= 1'b0;
		frame(8'h06, 1'b0, 24'h0, 4'h0, 3'h0, 16'h0);
		frame(8'h42, 1'b1, 24'h002000, 4'h0, 3'h1, 16'h5a);
		idle_wait();
		frame(8'h06, 1'b0, 24'h0, 4'h0, 3'h0, 16'h0);
		frame(8'h44, 1'b0, 24'h002000, 4'h0, 3'h0, 16'h0);
		frame(8'h05, 1'b0, 24'h0, 4'h0, 3'h1, 16'h0);
		chk(rd, 32'h02);
		frame(8'h48, 1'b1, 24'h002000, 4'h8, 3'h1, 16'h0);
		chk(rd, 32'h5a);
		frame(8'h04, 1'b0, 24'h0, 4'h0, 3'h0, 16'h0);
		frame(8'h05, 1'b0, 24'h0, 4'h0, 3'h1, 16'h0);
		chk(rd, 32'h0);
		frame(8'h42, 1'b1, 24'h002001, 4'h0, 3'h1, 16'h0);
		frame(8'h48, 1'b1, 24'h002000, 4'h8, 3'h2, 16'h0);
		chk(rd, 32'hff5a);
		srst <= 1'b1;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		chk({26'h0, link.cs_n, write_in_progress, write_enable_latch, area_lock}, 32'h20);
		ahb(1'b1, osr_pkg::REG_CTRL, 32'h00010005);
		ahb(1'b0, osr_pkg::REG_STAT, 32'h0);
		chk(rd & 32'h3, 32'h0);
		ahb(1'b1, 32'h20, 32'hffffffff);
		ahb(1'b0, 32'h20, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		por_wait();
		frame(8'h48, 1'b1, 24'h001000, 4'h8, 3'h4, 16'h0);
		chk(rd, 32'hffffffff);
		conclude();
	end
endmodule
